// *** verilog/bwp_pkg.sv ***
/*
 * Shared constants and carrier types for the block write-protect controller.
 * Assumes byte bit numbers are given with bit 0 as the most significant bit.
 * The constants below therefore hold the matching LSB-first vector index.
 */
`default_nettype none

package bwp_pkg;

    // status byte fields (vector index, MSB-first bit 2, 3, 5)
    localparam int unsigned STS_PROTECT_ENABLED_POS  = 5;
    localparam int unsigned STS_WRITE_FAULT_POS      = 4;
    localparam int unsigned STS_EXAMINE_POS          = 2;

    // command byte fields (vector index, MSB-first bit 0, 1, 2, 3)
    localparam int unsigned CMD_DISARM_POS           = 7;
    localparam int unsigned CMD_ARM_POS              = 6;
    localparam int unsigned CMD_PROTECT_ENABLE_POS   = 5;
    localparam int unsigned CMD_PROTECT_DISABLE_POS  = 4;

    // status answered by an acknowledge when nothing is pending
    localparam logic [7:0]  ACK_NONE_STATUS          = 8'h04;

    localparam int unsigned MASK_WORDS               = 8;
    localparam int unsigned MASK_BITS                = 64;
    localparam logic [2:0]  SEQ_RESET                = 3'h0;
    localparam logic [63:0] MASK_RESET               = 64'h0;

    // block-size strap codes
    typedef enum logic [1:0] {
        BWP_BLK_512  = 2'h0,
        BWP_BLK_1K   = 2'h1,
        BWP_BLK_2K   = 2'h2
    } bwp_blk_size_t;

    localparam logic [1:0]  STRAP_RESET              = 2'h0;

    // one programmed-I/O transfer from the processor
    typedef struct packed {
        logic       command_strobe;
        logic       byte_write_strobe;
        logic       status_request;
        logic       interrupt_acknowledge;
        logic [7:0] data;
    } bwp_bus_req_t;

    // byte returned to the processor
    typedef struct packed {
        logic       status_valid;
        logic       ack_valid;
        logic [7:0] data;
    } bwp_bus_rsp_t;

    localparam bwp_bus_rsp_t RSP_RESET = '{status_valid: 1'b0, ack_valid: 1'b0, data: 8'h00};

endpackage : bwp_pkg

`default_nettype wire

// *** verilog/bwp_mask_store.sv ***
/*
 * 64-bit protect mask store: byte-wide write port, single-bit registered read.
 * Assumes write index and read index come from logic on the same clock.
 */
`default_nettype none
`timescale 1ns/100ps

module bwp_mask_store
    import bwp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_word,
    input  wire logic [7:0] wr_data,
    input  wire logic [5:0] rd_block,
    output var  logic       rd_bit
);

    logic [MASK_BITS-1:0] mask;

    // block b lives in word b/8, MSB-first bit b%8
    genvar w;
    generate
        for (w = 0; w < MASK_WORDS; w++) begin : g_word
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mask[w*8 +: 8] <= MASK_RESET[w*8 +: 8];
                end else if (wr_en && wr_word == 3'(w)) begin
                    mask[w*8 +: 8] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_bit <= 1'b0;
        end else begin
            rd_bit <= mask[{rd_block[5:3], ~rd_block[2:0]}];
        end
    end

endmodule // bwp_mask_store

`default_nettype wire

// *** verilog/bwp_controller.sv ***
/*
 * Block write-protect controller: mask store load sequencer, address check,
 * write-to-read conversion, status and command bytes, interrupt request.
 * Assumes the processor drives all inputs on clk; the strap is static.
 */
`default_nettype none
`timescale 1ns/100ps

module bwp_controller
    import bwp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          system_clear,
    input  wire logic [1:0]    block_size_strap,
    input  wire bwp_bus_req_t  bus_req,
    output var  bwp_bus_rsp_t  bus_rsp,
    input  wire logic [15:0]   mem_addr,
    input  wire logic          write_attempt,
    input  wire logic          protect_override,
    output var  logic          protected_address_hit,
    output var  logic          write_to_read_convert,
    output var  logic          attention_set,
    output var  logic          interrupt_request
);

    logic [1:0] strap;
    logic       strap_taken;
    logic [2:0] mask_seq;
    logic [5:0] block_index;
    logic       hit_bit;
    logic       attempt_d;
    logic       protect_enabled;
    logic       protected_write_fault;
    logic       examine_flag;
    logic       armed;
    logic       fault_event;
    logic       cmd_take;
    logic       data_take;
    logic       ack_take;
    logic [7:0] status_byte;
    logic [7:0] next_status_after_ack;

    assign cmd_take  = bus_req.command_strobe;
    assign data_take = bus_req.byte_write_strobe && !bus_req.command_strobe;
    assign ack_take  = bus_req.interrupt_acknowledge;

    // strap caught once, right after reset release
    // a later strap change cannot move block boundaries under a running program
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap       <= STRAP_RESET;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap       <= block_size_strap;
            strap_taken <= 1'b1;
        end
    end

    // block index for the selected block size
    always_comb begin
        case (bwp_blk_size_t'(strap))
            BWP_BLK_512: block_index = mem_addr[14:9];
            BWP_BLK_1K:  block_index = mem_addr[15:10];
            BWP_BLK_2K:  block_index = {1'b0, mem_addr[15:11]};
            default:     block_index = mem_addr[14:9];
        endcase
    end

    // mask load sequencer: wraps after word 7
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_seq <= SEQ_RESET;
        end else if (system_clear || cmd_take) begin
            mask_seq <= SEQ_RESET;
        end else if (data_take) begin
            mask_seq <= mask_seq + 3'h1;
        end
    end

    bwp_mask_store u_mask (
        .clk      (clk),
        .rst_b    (rst_b),
        .wr_en    (data_take),
        .wr_word  (mask_seq),
        .wr_data  (bus_req.data),
        .rd_block (block_index),
        .rd_bit   (hit_bit)
    );

    // attempt delayed one cycle to line up with the registered mask bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            protected_address_hit <= 1'b0;
            attempt_d             <= 1'b0;
        end else begin
            protected_address_hit <= hit_bit;
            attempt_d             <= write_attempt;
        end
    end

    // hit_bit reflects the address presented with the attempt one cycle earlier
    assign fault_event = attempt_d && hit_bit && protect_enabled
                         && !protect_override;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_to_read_convert <= 1'b0;
            attention_set         <= 1'b0;
        end else begin
            write_to_read_convert <= fault_event;
            attention_set         <= fault_event;
        end
    end

    // protect enable; disable wins when both command bits are set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            protect_enabled <= 1'b0;
        end else if (system_clear) begin
            protect_enabled <= 1'b0;
        end else if (cmd_take) begin
            if (bus_req.data[CMD_PROTECT_DISABLE_POS]) begin
                protect_enabled <= 1'b0;
            end else if (bus_req.data[CMD_PROTECT_ENABLE_POS]) begin
                protect_enabled <= 1'b1;
            end
        end
    end

    // arm state; disarm wins when both are set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (system_clear) begin
            armed <= 1'b0;
        end else if (cmd_take) begin
            if (bus_req.data[CMD_DISARM_POS]) begin
                armed <= 1'b0;
            end else if (bus_req.data[CMD_ARM_POS]) begin
                armed <= 1'b1;
            end
        end
    end

    // fault and examine flags: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            protected_write_fault <= 1'b0;
            examine_flag          <= 1'b0;
        end else if (fault_event) begin
            protected_write_fault <= 1'b1;
            examine_flag          <= 1'b1;
        end else if (system_clear || cmd_take || (ack_take && interrupt_request)) begin
            protected_write_fault <= 1'b0;
            examine_flag          <= 1'b0;
        end
    end

    // interrupt: only queued while armed; disarm drops a pending one
    // a fault in the same cycle as a clear still raises the request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            interrupt_request <= 1'b0;
        end else if (fault_event && armed) begin
            interrupt_request <= 1'b1;
        end else if (system_clear) begin
            interrupt_request <= 1'b0;
        end else if (cmd_take && bus_req.data[CMD_DISARM_POS]) begin
            interrupt_request <= 1'b0;
        end else if (ack_take) begin
            interrupt_request <= 1'b0;
        end
    end

    // byte bits count MSB-first, so status bit 2 sits at vector index 5
    always_comb begin
        status_byte                          = 8'h00;
        status_byte[STS_PROTECT_ENABLED_POS] = protect_enabled;
        status_byte[STS_WRITE_FAULT_POS]     = protected_write_fault;
        status_byte[STS_EXAMINE_POS]         = examine_flag;
        next_status_after_ack                          = 8'h00;
        next_status_after_ack[STS_PROTECT_ENABLED_POS] = protect_enabled;
    end

    // answers to status request and interrupt acknowledge
    // acknowledge of a pending interrupt reports status as it stands after its own clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rsp <= RSP_RESET;
        end else begin
            bus_rsp.status_valid <= bus_req.status_request && !ack_take;
            bus_rsp.ack_valid    <= ack_take;
            if (ack_take) begin
                bus_rsp.data <= interrupt_request ? next_status_after_ack
                                                  : ACK_NONE_STATUS;
            end else if (bus_req.status_request) begin
                bus_rsp.data <= status_byte;
            end else begin
                bus_rsp.data <= 8'h00;
            end
        end
    end

endmodule // bwp_controller

`default_nettype wire

// *** sim/bwp_controller_properties.sv ***
/* Port checker for bwp_controller.
   Bound to every bwp_controller instance; sees only its ports. */
`default_nettype none
`timescale 1ns/100ps

module bwp_controller_properties
    import bwp_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_b,
    input wire bwp_bus_req_t bus_req,
    input wire bwp_bus_rsp_t bus_rsp,
    input wire logic         write_attempt,
    input wire logic         protect_override,
    input wire logic         protected_address_hit,
    input wire logic         write_to_read_convert,
    input wire logic         attention_set,
    input wire logic         interrupt_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic cv = write_to_read_convert;
    wire logic sense = bus_req.status_request && !bus_req.interrupt_acknowledge;

    // command with given enable/disable bits, quiet gap, then a status read
    sequence s_cmd_sense(v);
        bus_req.command_strobe && bus_req.data[5:4] == v ##1 !cv ##1 sense && !cv;
    endsequence

    property p_cmd_on;
        s_cmd_sense(2'b10) |=> bus_rsp.data[5] && (!bus_rsp.data[4] || cv);
    endproperty
    a_cmd_on: assert property (p_cmd_on)
        else $error("enable command misread");
    property p_cmd_off;
        s_cmd_sense(2'b01) |=> !bus_rsp.data[5] && (!bus_rsp.data[4] || cv);
    endproperty
    a_cmd_off: assert property (p_cmd_off)
        else $error("disable command misread");
    property p_status_fmt;
        sense |=> bus_rsp.status_valid && (bus_rsp.data & 8'hCB) == 8'h00;
    endproperty
    a_status_fmt: assert property (p_status_fmt)
        else $error("status answer bad");
    property p_examine;
        bus_rsp.status_valid |-> bus_rsp.data[2] == bus_rsp.data[4];
    endproperty
    a_examine: assert property (p_examine)
        else $error("examine apart from fault");
    property p_convert_cause;
        cv |-> $past(write_attempt, 2) && !$past(protect_override) && protected_address_hit;
    endproperty
    a_convert_cause: assert property (p_convert_cause)
        else $error("convert uncaused");
    property p_convert_atn;
        cv |-> attention_set ##1 !cv;
    endproperty
    a_convert_atn: assert property (p_convert_atn)
        else $error("attention not paired");
    property p_irq_source;
        $rose(interrupt_request) |-> cv;
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("irq without fault");
    property p_ack;
        bus_req.interrupt_acknowledge |=> bus_rsp.ack_valid && !bus_rsp.status_valid;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack not answered");
    property p_ack_clear;
        bus_req.interrupt_acknowledge && interrupt_request |=> !interrupt_request || cv;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack left irq");
    property p_disarm;
        bus_req.command_strobe && bus_req.data[7] |=> !interrupt_request || cv;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("disarm left irq");
endmodule // bwp_controller_properties

bind bwp_controller bwp_controller_properties u_props (.clk, .rst_b, .bus_req, .bus_rsp,
    .write_attempt, .protect_override, .protected_address_hit, .write_to_read_convert,
    .attention_set, .interrupt_request);

`default_nettype wire

// *** sim/bwp_host_model.sv ***
/* Host processor stand-in: gates write attempts by its mode bit,
   keeps a condition code from each status answer. */
`default_nettype none
`timescale 1ns/100ps

module bwp_host_model
    import bwp_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         user_mode,
    input  wire logic         write_req,
    input  wire bwp_bus_rsp_t rsp,
    output logic              write_attempt,
    output logic [3:0]        cond_code
);
    assign write_attempt = write_req && user_mode;
    always_ff @(posedge clk) begin
        if (rsp.status_valid) begin
            cond_code <= rsp.data[3:0];
        end
    end
endmodule // bwp_host_model

`default_nettype wire

// *** sim/testbench.sv ***
/* Self-checking bench for bwp_controller.
   Needs bwp_pkg, the design, its checker and bwp_host_model. */
`default_nettype none
`timescale 1ns/100ps

module testbench
    import bwp_pkg::*;
;
    logic         clk, rst_b, system_clear, protect_override, user_mode, write_req;
    logic         write_attempt, hit, cv, atn, irq, pe, flt, armd, pend;
    logic [1:0]   strap;
    logic [2:0]   wptr;
    logic [15:0]  mem_addr;
    logic [3:0]   cond_code;
    logic [7:0]   mask [8];
    logic [31:0]  seed;
    bwp_bus_req_t bus_req;
    bwp_bus_rsp_t bus_rsp, rsp_seen;
    int           mismatches, tests_run;

    bwp_host_model host (.clk(clk), .user_mode(user_mode), .write_req(write_req),
        .rsp(bus_rsp), .write_attempt(write_attempt), .cond_code(cond_code));
    bwp_controller uut (.clk(clk), .rst_b(rst_b), .system_clear(system_clear),
        .block_size_strap(strap), .bus_req(bus_req), .bus_rsp(bus_rsp), .mem_addr(mem_addr),
        .write_attempt(write_attempt), .protect_override(protect_override),
        .protected_address_hit(hit), .write_to_read_convert(cv), .attention_set(atn),
        .interrupt_request(irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [5:0] blk(input logic [15:0] a, input logic [1:0] s);
        case (s)
            2'h1: return a[15:10];
            2'h2: return {1'b0, a[15:11]};
            default: return a[14:9];
        endcase
    endfunction
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // one transfer, answer captured, then an idle cycle
    task automatic send(input logic [11:0] r);
        bus_req = r;
        @(negedge clk);
        rsp_seen = bus_rsp;
        bus_req = '0;
        @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] d);
        send({4'h8, d});
        pe = d[4] ? 1'b0 : (d[5] ? 1'b1 : pe);
        armd = d[7] ? 1'b0 : (d[6] ? 1'b1 : armd);
        pend = pend & ~d[7];
        flt = 1'b0;
        wptr = 3'h0;
    endtask
    task automatic sense();
        send(12'h200);
        chk(rsp_seen === {4'h8, pe, flt, 1'b0, flt, 2'b00}, "status");
        chk(cond_code === {1'b0, flt, 2'b00}, "cond code");
    endtask
    task automatic ack();
        send(12'h100);
        chk(rsp_seen === {2'b01, pend ? {2'b00, pe, 5'h00} : 8'h04}, "ack");
        flt = pend ? 1'b0 : flt;
        pend = 1'b0;
        chk(irq === 1'b0, "irq after ack");
    endtask
    task automatic load(input int n);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            mask[wptr] = seed[7:0];
            wptr = wptr + 3'h1;
            send({4'h4, seed[7:0]});
        end
    endtask
    task automatic attempt(input logic [15:0] a, input logic u, input logic o);
        logic [5:0] b;
        logic       hb, seen, seen_atn;
        b = blk(a, strap);
        hb = mask[b[5:3]][3'h7 - b[2:0]];
        seen = 1'b0;
        seen_atn = 1'b0;
        mem_addr = a;
        user_mode = u;
        protect_override = o;
        write_req = 1'b1;
        @(negedge clk);
        write_req = 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            if (i == 0) chk(hit === hb, "hit");
            seen = seen | (cv === 1'b1);
            seen_atn = seen_atn | (atn === 1'b1);
        end
        hb = hb & u & pe & !o;
        chk(seen === hb, "convert");
        chk(seen_atn === hb, "attention");
        flt = flt | hb;
        pend = pend | (hb & armd);
        chk(irq === pend, "irq");
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_b, system_clear, protect_override, user_mode, write_req} = '0;
        {bus_req, mem_addr, strap} = '0;
        seed = 32'h0607;
        mismatches = 0;
        tests_run = 0;
        for (int s = 0; s < 4; s++) begin
            strap = s[1:0];
            rst_b = 1'b0;
            {pe, flt, armd, pend, wptr} = '0;
            repeat (5) @(negedge clk);
            rst_b = 1'b1;
            @(negedge clk);
            load(11);
            system_clear = 1'b1;
            @(negedge clk);
            system_clear = 1'b0;
            wptr = 3'h0;
            load(1);
            cmd(8'h60);
            sense();
            for (int k = 0; k < 16; k++) begin
                seed = xs(seed);
                attempt(seed[15:0], seed[17] | seed[18], seed[19] & seed[20]);
            end
            sense();
            ack();
            ack();
            cmd(8'hA0);
            mask[0] = 8'h80;
            send(12'h480);
            attempt(16'h0000, 1'b1, 1'b0);
            sense();
            cmd(8'h30);
            sense();
            attempt(16'h0000, 1'b1, 1'b0);
            cmd(8'h20);
            cmd(8'h10);
            sense();
        end
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
